// >>> rtl/status_word_defs.svh
// constants for the status word transfer block
`ifndef STATUS_WORD_DEFS_SVH
`define STATUS_WORD_DEFS_SVH

// ----------------------------------------------------------------
// status word layout
// ----------------------------------------------------------------
`define FLAG_MSB          31
`define FLAG_LSB          28
`define IRQ_DISABLE_BIT   7
`define FIQ_DISABLE_BIT   6
`define MODE_MSB          4
`define DEFINED_MASK      32'hf00000df
`define CURRENT_RESET     32'h000000d3
`define SAVED_RESET       32'h00000000

// ----------------------------------------------------------------
// mode field codes
// ----------------------------------------------------------------
`define MODE_USER         5'h10
`define MODE_FIQ          5'h11
`define MODE_IRQ          5'h12
`define MODE_SVC          5'h13
`define MODE_ABT          5'h17
`define MODE_UND          5'h1b

// ----------------------------------------------------------------
// instruction fields and decode patterns
// ----------------------------------------------------------------
`define COND_MSB          31
`define COND_LSB          28
`define TARGET_SAVED_BIT  22
`define SET_FLAGS_BIT     20
`define CLASS_REG         5'h02
`define CLASS_IMM         5'h06
`define READ_PATTERN      6'h0f
`define WHOLE_PATTERN     18'h29f00
`define FLAGS_PATTERN     10'h28f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define XFER_CYCLES       1

`endif

// >>> rtl/status_word_pkg.sv
// types shared by the status word transfer block
package status_word_pkg;

	typedef enum logic [1:0] {
		op_none,
		op_read,
		op_write_whole,
		op_write_flags
	} xfer_op_type;

	typedef logic [31:0] word_type;

endpackage : status_word_pkg

// >>> rtl/cond_check.sv
// condition field evaluator against the current flags
`timescale 1ns/1ps

module cond_check
	import status_word_pkg::*;
(
	input  wire logic [3:0] cond,
	input  wire logic [3:0] flags,
	output logic            pass
);

	logic n_flag;
	logic z_flag;
	logic c_flag;
	logic v_flag;

	// ----------------------------------------------------------------
	// flag order is negative, zero, carry, overflow
	// ----------------------------------------------------------------
	assign n_flag = flags[3];
	assign z_flag = flags[2];
	assign c_flag = flags[1];
	assign v_flag = flags[0];

	// one term per condition code
	always_comb
	begin
		unique case (cond)
			4'h0: pass = z_flag;
			4'h1: pass = !z_flag;
			4'h2: pass = c_flag;
			4'h3: pass = !c_flag;
			4'h4: pass = n_flag;
			4'h5: pass = !n_flag;
			4'h6: pass = v_flag;
			4'h7: pass = !v_flag;
			4'h8: pass = c_flag && !z_flag;
			4'h9: pass = !c_flag || z_flag;
			4'ha: pass = (n_flag == v_flag);
			4'hb: pass = (n_flag != v_flag);
			4'hc: pass = !z_flag && (n_flag == v_flag);
			4'hd: pass = z_flag || (n_flag != v_flag);
			4'he: pass = 1'b1;
			4'hf: pass = 1'b0;
		endcase
	end

endmodule : cond_check

// >>> rtl/status_word_transfer.sv
// status word read and write execution with mode-banked saved words
//
// Contract
// - a transfer acts only when its condition field passes, otherwise no status word or destination data changes.
// - transfers are decoded from the four compare and test opcodes with set-flags clear.
// - a status read copies all 32 bits of the selected word into the destination register.
// - a whole-word status write loads the selected word from the source register, mode permitting.
// - a flags-only write puts the top four bits of register or immediate into bits 31 to 28 only.
// - written bits 31, 30, 29 and 28 become the negative, zero, carry and overflow flags.
// - in user mode any write to the current word changes only its four flags.
// - in a privileged mode a whole-word write replaces every defined bit of the current word.
// - the saved word used is the one banked for the mode current at execution.
// - eleven bits are defined, bits 27 to 8 and bit 5 are reserved.
// - each transfer completes in exactly one instruction cycle.
`timescale 1ns/1ps
`include "status_word_defs.svh"

module status_word_transfer
	import status_word_pkg::*;
#(
	parameter int NUM_BANKS = 5
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr,
	input  wire logic [31:0] src_reg_data,
	output logic             dest_write,
	output logic [3:0]       dest_index,
	output logic [31:0]      dest_data,
	output logic [31:0]      current_status_word,
	output logic [31:0]      saved_status_word,
	output logic             xfer_done
);

	xfer_op_type op;
	logic        cond_pass;
	logic        execute;
	logic        to_saved;
	logic        user_mode;
	logic [2:0]  bank_sel;
	logic        bank_hit;
	word_type    write_value;
	word_type    cur_q;
	word_type    cur_d;
	word_type    bank_q [NUM_BANKS];
	word_type    bank_d [NUM_BANKS];
	word_type    saved_view_q;
	word_type    saved_view_d;
	logic        dest_write_q;
	logic        dest_write_d;
	logic [3:0]  dest_index_q;
	logic [3:0]  dest_index_d;
	word_type    dest_data_q;
	word_type    dest_data_d;
	logic        done_q;
	logic        done_d;
	logic [2:0]  view_sel;
	logic        view_hit;
	logic [3:0]  bank_code;
	logic [3:0]  view_code;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// bank index for a mode, hit low for user or unknown modes
	function automatic logic [3:0] bank_of(input logic [4:0] mode);
		logic [3:0] r;
		r = 4'h0;
		unique case (mode)
			`MODE_FIQ: r = 4'h8;
			`MODE_IRQ: r = 4'h9;
			`MODE_SVC: r = 4'ha;
			`MODE_ABT: r = 4'hb;
			`MODE_UND: r = 4'hc;
			default:   r = 4'h0;
		endcase
		return r;
	endfunction : bank_of

	// 8-bit immediate rotated right by twice the rotate field
	function automatic word_type rotate_imm(input logic [11:0] field);
		word_type   base;
		logic [5:0] rsh;
		logic [5:0] lsh;
		base = {24'h000000, field[7:0]};
		rsh  = {1'b0, field[11:8], 1'b0};
		lsh  = 6'd32 - rsh;
		return (base >> rsh) | (base << lsh);
	endfunction : rotate_imm

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------

	cond_check u_cond (
		.cond  (instr[`COND_MSB:`COND_LSB]),
		.flags (cur_q[`FLAG_MSB:`FLAG_LSB]),
		.pass  (cond_pass)
	);

	// opcode space of test and compare ops with set-flags clear
	always_comb
	begin
		op = op_none;
		if (instr[27:23] == `CLASS_REG && instr[21:16] == `READ_PATTERN
			&& instr[11:0] == 12'h000)
			op = op_read;
		else if (instr[27:23] == `CLASS_REG && instr[21:4] == `WHOLE_PATTERN)
			op = op_write_whole;
		else if (instr[27:23] == `CLASS_REG && instr[21:12] == `FLAGS_PATTERN
			&& instr[11:4] == 8'h00)
			op = op_write_flags;
		else if (instr[27:23] == `CLASS_IMM && instr[21:12] == `FLAGS_PATTERN)
			op = op_write_flags;
	end

	// execution gate, target and banked word selection
	always_comb
	begin
		execute     = instr_valid && (op != op_none) && cond_pass;
		to_saved    = instr[`TARGET_SAVED_BIT];
		user_mode   = (cur_q[`MODE_MSB:0] == `MODE_USER);
		bank_code   = bank_of(cur_q[`MODE_MSB:0]);
		bank_sel    = bank_code[2:0];
		bank_hit    = bank_code[3];
		write_value = (instr[27:23] == `CLASS_IMM) ? rotate_imm(instr[11:0]) : src_reg_data;
	end

	// ----------------------------------------------------------------
	// current status word
	// ----------------------------------------------------------------

	always_comb
	begin
		cur_d = cur_q;
		if (execute && !to_saved && op == op_write_whole && !user_mode)
			cur_d = write_value & `DEFINED_MASK;
		else if (execute && !to_saved && (op == op_write_whole || op == op_write_flags))
			cur_d = {write_value[`FLAG_MSB:`FLAG_LSB], cur_q[27:0]};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cur_q <= `CURRENT_RESET;
		else
			cur_q <= cur_d;
	end

	// ----------------------------------------------------------------
	// banked saved words, one per privileged mode
	// ----------------------------------------------------------------

	for (genvar g = 0; g < NUM_BANKS; g++)
	begin : g_bank
		always_comb
		begin
			bank_d[g] = bank_q[g];
			if (execute && to_saved && bank_hit && bank_sel == 3'(g))
			begin
				if (op == op_write_whole)
					bank_d[g] = write_value & `DEFINED_MASK;
				else if (op == op_write_flags)
					bank_d[g] = {write_value[`FLAG_MSB:`FLAG_LSB], bank_q[g][27:0]};
			end
		end

		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				bank_q[g] <= `SAVED_RESET;
			else
				bank_q[g] <= bank_d[g];
		end
	end

	// ----------------------------------------------------------------
	// read result, completion strobe and saved word view
	// ----------------------------------------------------------------

	always_comb
	begin
		view_code    = bank_of(cur_d[`MODE_MSB:0]);
		view_sel     = view_code[2:0];
		view_hit     = view_code[3];
		saved_view_d = view_hit ? bank_d[view_sel] : `SAVED_RESET;
		dest_write_d = execute && (op == op_read);
		dest_index_d = instr[15:12];
		dest_data_d  = dest_data_q;
		if (execute && op == op_read)
			dest_data_d = to_saved ? (bank_hit ? bank_q[bank_sel] : `SAVED_RESET) : cur_q;
		done_d       = execute;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			saved_view_q <= `SAVED_RESET;
			dest_write_q <= 1'b0;
			dest_index_q <= 4'h0;
			dest_data_q  <= 32'h00000000;
			done_q       <= 1'b0;
		end
		else
		begin
			saved_view_q <= saved_view_d;
			dest_write_q <= dest_write_d;
			dest_index_q <= dest_index_d;
			dest_data_q  <= dest_data_d;
			done_q       <= done_d;
		end
	end

	assign current_status_word = cur_q;
	assign saved_status_word   = saved_view_q;
	assign dest_write          = dest_write_q;
	assign dest_index          = dest_index_q;
	assign dest_data           = dest_data_q;
	assign xfer_done           = done_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_cur_write;
		instr_valid && cond_pass && !to_saved && (op == op_write_whole || op == op_write_flags);
	endsequence

	sequence s_done_pulse;
		xfer_done ##1 (!xfer_done || $past(execute));
	endsequence

	AST_COND_FAIL: assert property (instr_valid && !cond_pass |=>
		$stable(current_status_word) && !dest_write && !xfer_done)
		else $error("failed condition changed state");
	AST_SET_FLAGS_IGNORED: assert property (instr_valid && instr[`SET_FLAGS_BIT] |=>
		!dest_write && $stable(current_status_word))
		else $error("set-flags form taken as transfer");
	AST_READ_CURRENT: assert property (execute && op == op_read && !to_saved |=>
		dest_write && dest_data == $past(current_status_word))
		else $error("status read returned wrong word");
	AST_WHOLE_PRIV: assert property (s_cur_write and (op == op_write_whole && !user_mode) |=>
		current_status_word == ($past(src_reg_data) & `DEFINED_MASK))
		else $error("privileged whole write wrong");
	AST_USER_PROTECT: assert property (s_cur_write and user_mode |=>
		current_status_word[27:0] == $past(current_status_word[27:0]))
		else $error("user write altered control bits");
	AST_FLAGS_ONLY: assert property (s_cur_write and (op == op_write_flags) |=>
		current_status_word[31:28] == $past(write_value[31:28])
		&& current_status_word[27:0] == $past(current_status_word[27:0]))
		else $error("flags-only write wrong");
	AST_RESERVED_ZERO: assert property (((current_status_word | saved_status_word)
		& ~`DEFINED_MASK) == 32'h00000000)
		else $error("reserved bit not zero");
	AST_SAVED_BANK: assert property (execute && to_saved && bank_hit
		&& op == op_write_whole |=> saved_status_word == ($past(src_reg_data) & `DEFINED_MASK))
		else $error("saved write missed current bank");
	AST_ONE_CYCLE: assert property (execute |-> ##1 s_done_pulse)
		else $error("transfer not done in one cycle");

endmodule : status_word_transfer

// >>> tb/status_word_transfer_bench.sv
// self-checking bench for the status word transfer block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin err_count++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end end

module status_word_transfer_bench import status_word_pkg::*;;

	typedef struct packed {logic rd; logic [3:0] idx; logic [31:0] data, cur, sav;} note_type;

	logic        clk;
	logic        rst_n;
	logic        instr_valid;
	logic [31:0] instr;
	logic [31:0] src_reg_data;
	logic        dest_write;
	logic [3:0]  dest_index;
	logic [31:0] dest_data;
	logic [31:0] current_status_word;
	logic [31:0] saved_status_word;
	logic        xfer_done;
	note_type    notes[$];
	note_type    mon_n;
	logic [31:0] cur_m;
	logic [31:0] bank[32];
	logic [4:0]  modes[5] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1b};
	int          err_count;
	int          comparisons;

	// ----------------------------------------------------------------
	// clock and design
	// ----------------------------------------------------------------
	initial clk = 1'b0;
	always #5 clk = ~clk;

	status_word_transfer dut (
		.clk                 (clk),
		.rst_n               (rst_n),
		.instr_valid         (instr_valid),
		.instr               (instr),
		.src_reg_data        (src_reg_data),
		.dest_write          (dest_write),
		.dest_index          (dest_index),
		.dest_data           (dest_data),
		.current_status_word (current_status_word),
		.saved_status_word   (saved_status_word),
		.xfer_done           (xfer_done)
	);

	// ----------------------------------------------------------------
	// reference model helpers
	// ----------------------------------------------------------------
	// saved word of a mode, zero where the mode has none
	function automatic logic [31:0] sv(input logic [4:0] m);
		return (m inside {5'h11, 5'h12, 5'h13, 5'h17, 5'h1b}) ? bank[m] : 32'h0;
	endfunction : sv

	// only the condition codes the bench uses
	function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
		case (c)
			4'h0: return f[2];
			4'h1: return !f[2];
			4'he: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : cond_ok

	// kind 0 read, 1 whole write, 2 flags from register, 3 flags from immediate
	task automatic issue(input int kind, input logic p, input logic [3:0] c,
		input logic [3:0] idx, input logic [31:0] src, input logic [3:0] rot,
		input logic [7:0] imm, input logic sflag);
		logic [31:0] ins;
		logic [31:0] val;
		logic [63:0] t;
		logic [4:0]  m;
		note_type    n;
		if (idx == 4'hf)
			idx = 4'he;
		if (kind == 1 && (p || cur_m[4:0] != 5'h10))
			src = src & 32'hf00000df;
		t = {24'h0, imm, 24'h0, imm} >> (2 * rot);
		val = (kind == 3) ? t[31:0] : src;
		case (kind)
			0: ins = {c, 5'b00010, p, 6'h0f, idx, 12'h000};
			1: ins = {c, 5'b00010, p, 18'h29f00, idx};
			2: ins = {c, 5'b00010, p, 10'h28f, 8'h00, idx};
			default: ins = {c, 5'b00110, p, 10'h28f, rot, imm};
		endcase
		ins[20] = sflag;
		m = cur_m[4:0];
		n = '0;
		if (!sflag && cond_ok(c, cur_m[31:28]))
		begin
			n.rd = (kind == 0);
			n.data = p ? sv(m) : cur_m;
			n.idx = idx;
			if (kind == 1 && !p)
				cur_m = (m == 5'h10) ? {val[31:28], cur_m[27:0]} : val & 32'hf00000df;
			else if (kind > 1 && !p)
				cur_m[31:28] = val[31:28];
			else if (kind == 1)
				bank[m] = val & 32'hf00000df;
			else if (kind > 1)
				bank[m][31:28] = val[31:28];
			n.cur = cur_m;
			n.sav = sv(cur_m[4:0]);
			notes.push_back(n);
		end
		@(negedge clk);
		instr_valid = 1'b1;
		instr = ins;
		src_reg_data = src;
	endtask : issue

	task automatic idle();
		@(negedge clk);
		instr_valid = 1'b0;
		repeat (3) @(negedge clk);
	endtask : idle

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// monitor: one note per completed transfer, one cycle after issue
	// ----------------------------------------------------------------
	always @(posedge clk)
	begin
		#1;
		if (rst_n && xfer_done === 1'b1 && notes.size() == 0)
		begin
			`CHK("refused done", 1'b0, xfer_done);
		end
		else if (rst_n && xfer_done === 1'b1)
		begin
			mon_n = notes.pop_front();
			`CHK("dest write", mon_n.rd, dest_write);
			if (mon_n.rd)
			begin
				`CHK("dest data", mon_n.data, dest_data);
				`CHK("dest index", mon_n.idx, dest_index);
			end
			`CHK("current word", mon_n.cur, current_status_word);
			`CHK("saved word", mon_n.sav, saved_status_word);
		end
		else if (rst_n)
		begin
			`CHK("idle done", 1'b0, xfer_done);
			`CHK("idle write", 1'b0, dest_write);
		end
	end

	// ----------------------------------------------------------------
	// watchdog: the tests need well under 1000 cycles
	// ----------------------------------------------------------------
	initial
	begin
		#100000;
		err_count++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		instr_valid = 1'b0;
		instr = 32'h0;
		src_reg_data = 32'h0;
		rst_n = 1'b0;
		err_count = 0;
		comparisons = 0;
		cur_m = 32'h000000d3;
		foreach (bank[i]) bank[i] = 32'h0;
		void'($urandom(43369));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		`CHK("reset current", 32'h000000d3, current_status_word);
		`CHK("reset saved", 32'h0, saved_status_word);
		$display("test reset done");
		// every privileged mode, back to back transfers
		for (int i = 0; i < 5; i++)
		begin
			issue(1, 1'b0, 4'he, 4'h0, ($urandom & 32'hffffffe0) | 32'(modes[i]),
				4'h0, 8'h00, 1'b0);
			issue(1, 1'b1, 4'he, 4'h0, $urandom, 4'h0, 8'h00, 1'b0);
			issue(3, 1'b1, 4'he, 4'h0, 32'h0, 4'($urandom), 8'($urandom), 1'b0);
			issue(2, 1'b0, 4'he, 4'h1, $urandom, 4'h0, 8'h00, 1'b0);
			issue(0, 1'b1, 4'he, 4'($urandom), $urandom, 4'h0, 8'h00, 1'b0);
			issue(0, 1'b0, 4'he, 4'($urandom), $urandom, 4'h0, 8'h00, 1'b0);
		end
		idle();
		$display("test privileged modes done");
		// condition field and set-flags bit
		issue(3, 1'b0, 4'he, 4'h0, 32'h0, 4'h4, 8'h40, 1'b0);
		issue(0, 1'b0, 4'h0, 4'h3, 32'h0, 4'h0, 8'h00, 1'b0);
		issue(1, 1'b0, 4'h1, 4'h0, 32'h00000010, 4'h0, 8'h00, 1'b0);
		issue(1, 1'b0, 4'hf, 4'h0, 32'h00000010, 4'h0, 8'h00, 1'b0);
		for (int k = 0; k < 4; k++)
			issue(k, 1'b0, 4'he, 4'h5, 32'h00000010, 4'h4, 8'hf0, 1'b1);
		issue(0, 1'b0, 4'he, 4'h9, 32'h0, 4'h0, 8'h00, 1'b0);
		idle();
		$display("test refusals done");
		// user mode protection
		issue(1, 1'b0, 4'he, 4'h0, $urandom & 32'hf0000010 | 32'h10, 4'h0, 8'h00, 1'b0);
		issue(1, 1'b0, 4'he, 4'h0, $urandom | 32'h0000001f, 4'h0, 8'h00, 1'b0);
		issue(2, 1'b0, 4'he, 4'h2, $urandom, 4'h0, 8'h00, 1'b0);
		issue(0, 1'b0, 4'he, 4'h7, 32'h0, 4'h0, 8'h00, 1'b0);
		issue(3, 1'b0, 4'he, 4'h0, 32'h0, 4'h2, 8'ha5, 1'b0);
		issue(0, 1'b0, 4'he, 4'hc, 32'h0, 4'h0, 8'h00, 1'b0);
		idle();
		$display("test user mode done");
		`CHK("notes drained", 0, notes.size());
		print_verdict();
	end

endmodule : status_word_transfer_bench
